//--- src/vpwl_regs.vh
// Register map, field positions, symbol codes and timing constants of the VPW link
`ifndef VPWL_REGS_VH
`define VPWL_REGS_VH

// Register byte offsets
`define VPWL_OFF_CTRL1 8'h00
`define VPWL_OFF_CTRL2 8'h04
`define VPWL_OFF_STATE 8'h08
`define VPWL_OFF_DATA 8'h0C

// control_register_one fields
`define VPWL_C1_IE 0
// control_register_two fields
`define VPWL_C2_LOOP 0
`define VPWL_C2_FOURFOLD_RATE_RECEIVE_ENABLE 1
// state_vector_register fields
`define VPWL_SV_RXFULL 0
`define VPWL_SV_TXEMPTY 1
`define VPWL_SV_EOF 2
`define VPWL_SV_INVALID 3
`define VPWL_SV_LOST 4
`define VPWL_SV_IDLE 5
`define VPWL_SV_BUSY 6

// Received symbol codes
`define VPWL_SYM_INV 4'h0
`define VPWL_SYM_BIT0 4'h1
`define VPWL_SYM_BIT1 4'h2
`define VPWL_SYM_EOD 4'h3
`define VPWL_SYM_EOF 4'h4
`define VPWL_SYM_EOFIFS 4'h5
`define VPWL_SYM_IDLE 4'h6
`define VPWL_SYM_SOF 4'h7
`define VPWL_SYM_BRK 4'h8

// Timing: clock period in ns, times in us, join window and arbitration filter in cycles
`define VPWL_CLK_NS 40
`define VPWL_CNT_W 14
`define VPWL_LIM_A_US 34
`define VPWL_LIM_B_US 96
`define VPWL_LIM_C_US 163
`define VPWL_LIM_D_US 239
`define VPWL_LIM_EOF_US 280
`define VPWL_LIM_IFS_US 300
`define VPWL_T64_US 64
`define VPWL_T128_US 128
`define VPWL_T200_US 200
`define VPWL_US2CYC(us) (((us) * 1000 + `VPWL_CLK_NS - 1) / `VPWL_CLK_NS)
// A time in us expressed in cycles of a short bit that lasts t64 cycles
`define VPWL_T64_SCALE(t64, us) (((t64) * (us)) / `VPWL_T64_US)
`define VPWL_JOIN_CYC 7'h68
`define VPWL_ARB_FILT 5'h10

`endif

//--- src/vpwl_sync.v
// Two-flop synchroniser for the bus receive pin
`timescale 1ns/1ps
module vpwl_sync (
    // Clock and reset
    input wire hclk,
    input wire hresetn,
    // Asynchronous in, synchronous out
    input wire din,
    output reg dout
);
    reg meta_q;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meta_q <= 1'b0;
            dout <= 1'b0;
        end else begin
            meta_q <= din;
            dout <= meta_q;
        end
    end
endmodule

//--- src/vpwl_width.v
// Pulse width measurement and symbol classification of the received line
`timescale 1ns/1ps
`include "vpwl_regs.vh"
module vpwl_width #(
    parameter W = 14,
    parameter [W-1:0] LA = 0,
    parameter [W-1:0] LB = 0,
    parameter [W-1:0] LC = 0,
    parameter [W-1:0] LD = 0,
    parameter [W-1:0] LEOF = 0,
    parameter [W-1:0] LIFS = 0
) (
    // Clock and reset
    input wire hclk,
    input wire hresetn,
    // Line level (1 = active) and fourfold rate select
    input wire rx,
    input wire quad,
    // Classified results
    output reg sym_stb,
    output reg [3:0] sym_code,
    output reg rise_stb,
    output reg eof_stb,
    output reg brk_stb,
    output wire idle
);
    reg rx_q;
    reg [W-1:0] cnt_q;
    reg [3:0] code;
    wire edge_w = rx ^ rx_q;

    // Fourfold rate shrinks every limit by four
    function [W-1:0] lim;
        input [W-1:0] v;
        input q;
        begin
            lim = q ? {2'b00, v[W-1:2]} : v;
        end
    endfunction

    // Contiguous windows: each maximum is the next minimum
    always @* begin
        code = `VPWL_SYM_INV;
        if (!rx_q) begin
            if (cnt_q < lim(LA, quad)) code = `VPWL_SYM_INV;
            else if (cnt_q < lim(LB, quad)) code = `VPWL_SYM_BIT0;
            else if (cnt_q < lim(LC, quad)) code = `VPWL_SYM_BIT1;
            else if (cnt_q < lim(LD, quad)) code = `VPWL_SYM_EOD;
            else if (cnt_q < lim(LEOF, quad)) code = `VPWL_SYM_EOF;
            else if (cnt_q < lim(LIFS, quad)) code = `VPWL_SYM_EOFIFS;
            else code = `VPWL_SYM_IDLE;
        end else begin
            if (cnt_q < lim(LA, quad)) code = `VPWL_SYM_INV;
            else if (cnt_q < lim(LB, quad)) code = `VPWL_SYM_BIT1;
            else if (cnt_q < lim(LC, quad)) code = `VPWL_SYM_BIT0;
            else if (cnt_q < lim(LD, quad)) code = `VPWL_SYM_SOF;
            else code = `VPWL_SYM_BRK;
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_q <= 1'b0;
            cnt_q <= {W{1'b0}};
            sym_stb <= 1'b0;
            sym_code <= `VPWL_SYM_INV;
            rise_stb <= 1'b0;
            eof_stb <= 1'b0;
            brk_stb <= 1'b0;
        end else begin
            rx_q <= rx;
            sym_stb <= edge_w;
            rise_stb <= edge_w & rx;
            if (edge_w) begin
                sym_code <= code;
                cnt_q <= {W{1'b0}};
            end else if (cnt_q != {W{1'b1}}) begin
                cnt_q <= cnt_q + 1'b1;
            end
            eof_stb <= !rx_q && !edge_w && (cnt_q == lim(LEOF, quad));
            brk_stb <= rx_q && !edge_w && (cnt_q == lim(LD, quad));
        end
    end

    assign idle = !rx_q && (cnt_q >= lim(LIFS, quad));
endmodule

//--- src/vpwl_core.v
// VPW link controller: AHB-Lite registers, receive framing, transmit and arbitration
//
// Our own choices: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ps
`include "vpwl_regs.vh"
module vpwl_core #(
    // Every limit and time but the join window and arbitration filter scales from the short bit, so one override retimes the link
    parameter [13:0] P_T64 = `VPWL_US2CYC(`VPWL_T64_US),
    parameter [13:0] P_LIM_A = `VPWL_T64_SCALE(P_T64, `VPWL_LIM_A_US),
    parameter [13:0] P_LIM_B = `VPWL_T64_SCALE(P_T64, `VPWL_LIM_B_US),
    parameter [13:0] P_LIM_C = `VPWL_T64_SCALE(P_T64, `VPWL_LIM_C_US),
    parameter [13:0] P_LIM_D = `VPWL_T64_SCALE(P_T64, `VPWL_LIM_D_US),
    parameter [13:0] P_LIM_EOF = `VPWL_T64_SCALE(P_T64, `VPWL_LIM_EOF_US),
    parameter [13:0] P_LIM_IFS = `VPWL_T64_SCALE(P_T64, `VPWL_LIM_IFS_US),
    parameter [13:0] P_T128 = `VPWL_T64_SCALE(P_T64, `VPWL_T128_US),
    parameter [13:0] P_T200 = `VPWL_T64_SCALE(P_T64, `VPWL_T200_US)
) (
    // Clock and reset
    input wire hclk,
    input wire hresetn,
    // AHB-Lite slave
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg hreadyout,
    output reg hresp,
    output reg [31:0] hrdata,
    // Bus pins (1 = active level)
    input wire bus_receive_input,
    output reg bus_transmit_output,
    // Interrupt request
    output reg irq
);
    localparam W = `VPWL_CNT_W;
    localparam [2:0] S_IDLE = 3'h0;
    localparam [2:0] S_WAIT = 3'h1;
    localparam [2:0] S_SOF = 3'h2;
    localparam [2:0] S_BIT = 3'h3;
    localparam [2:0] S_EDGE = 3'h4;
    localparam [2:0] S_XWAIT = 3'h5;
    localparam [6:0] JOIN_MAX = `VPWL_JOIN_CYC;

    // Registers
    reg ie_q, loop_q, quad_q;
    reg receive_full_flag_q, eof_q, inv_q, lost_q, transmit_empty_flag_q;
    reg [7:0] rsh_q, rsr_q, tsh_q, tshd_q;
    reg [2:0] rbit_q, bidx_q, st_q;
    reg ron_q, wr_q, drv_d1_q, drv_d2_q, lvl_q, first_q, eof_arm_q;
    reg [7:0] wad_q;
    reg [1:0] xtra_q;
    reg [W-1:0] tmr_q;
    reg [6:0] rise_age_q;
    reg [4:0] mm_q;
    reg [31:0] rd_d;

    wire rx_pin;
    wire sym_stb, rise_stb, eof_stb, brk_stb, bus_idle;
    wire [3:0] sym_code;

    vpwl_sync u_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .din(bus_receive_input),
        .dout(rx_pin)
    );

    // Receiver input source
    wire rx = loop_q ? bus_transmit_output : rx_pin;

    vpwl_width #(
        .W(W),
        .LA(P_LIM_A),
        .LB(P_LIM_B),
        .LC(P_LIM_C),
        .LD(P_LIM_D),
        .LEOF(P_LIM_EOF),
        .LIFS(P_LIM_IFS)
    ) u_width (
        .hclk(hclk),
        .hresetn(hresetn),
        .rx(rx),
        .quad(quad_q),
        .sym_stb(sym_stb),
        .sym_code(sym_code),
        .rise_stb(rise_stb),
        .eof_stb(eof_stb),
        .brk_stb(brk_stb),
        .idle(bus_idle)
    );

    // Bus access decode
    wire acc = hsel && htrans[1] && hready;
    wire rd_acc = acc && !hwrite;
    wire rd_data = rd_acc && (haddr[7:0] == `VPWL_OFF_DATA);
    wire rd_state = rd_acc && (haddr[7:0] == `VPWL_OFF_STATE);
    wire wr_c1 = wr_q && (wad_q == `VPWL_OFF_CTRL1);
    wire wr_c2 = wr_q && (wad_q == `VPWL_OFF_CTRL2);
    wire wr_data = wr_q && (wad_q == `VPWL_OFF_DATA);
    wire busy = (st_q != S_IDLE) && (st_q != S_WAIT);

    always @* begin
        rd_d = 32'h00000000;
        case (haddr[7:0])
            `VPWL_OFF_CTRL1: rd_d[`VPWL_C1_IE] = ie_q;
            `VPWL_OFF_CTRL2: begin
                rd_d[`VPWL_C2_LOOP] = loop_q;
                rd_d[`VPWL_C2_FOURFOLD_RATE_RECEIVE_ENABLE] = quad_q;
            end
            `VPWL_OFF_STATE: begin
                rd_d[`VPWL_SV_RXFULL] = receive_full_flag_q;
                rd_d[`VPWL_SV_TXEMPTY] = transmit_empty_flag_q;
                rd_d[`VPWL_SV_EOF] = eof_q;
                rd_d[`VPWL_SV_INVALID] = inv_q;
                rd_d[`VPWL_SV_LOST] = lost_q;
                rd_d[`VPWL_SV_IDLE] = bus_idle;
                rd_d[`VPWL_SV_BUSY] = busy;
            end
            `VPWL_OFF_DATA: rd_d[7:0] = rsh_q;
            default: rd_d = 32'h00000000;
        endcase
    end

    // Zero-wait slave, always OKAY
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b0;
            hresp <= 1'b0;
            hrdata <= 32'h00000000;
            wr_q <= 1'b0;
            wad_q <= 8'h00;
            ie_q <= 1'b0;
            loop_q <= 1'b0;
            irq <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            wr_q <= acc && hwrite;
            if (acc) begin
                wad_q <= haddr[7:0];
                hrdata <= hwrite ? 32'h00000000 : rd_d;
            end
            if (wr_c1) ie_q <= hwdata[`VPWL_C1_IE];
            if (wr_c2) loop_q <= hwdata[`VPWL_C2_LOOP];
            irq <= ie_q && (receive_full_flag_q || eof_q || inv_q);
        end
    end

    // Receive framing, holding stage and receive flags
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ron_q <= 1'b0;
            rbit_q <= 3'h0;
            rsr_q <= 8'h00;
            rsh_q <= 8'h00;
            receive_full_flag_q <= 1'b0;
            eof_q <= 1'b0;
            inv_q <= 1'b0;
            quad_q <= 1'b0;
            eof_arm_q <= 1'b0;
        end else begin
            // Clears first so a same-cycle event wins
            if (rd_data) receive_full_flag_q <= 1'b0;
            if (rd_state) begin
                eof_q <= 1'b0;
                inv_q <= 1'b0;
            end
            if (wr_c2) quad_q <= hwdata[`VPWL_C2_FOURFOLD_RATE_RECEIVE_ENABLE];
            if (eof_stb) eof_q <= 1'b1;
            if (sym_stb) begin
                eof_arm_q <= (sym_code == `VPWL_SYM_EOF) || (sym_code == `VPWL_SYM_EOFIFS)
                    || (sym_code == `VPWL_SYM_IDLE);
                case (sym_code)
                    `VPWL_SYM_SOF: begin
                        ron_q <= 1'b1;
                        rbit_q <= 3'h0;
                    end
                    `VPWL_SYM_BIT0, `VPWL_SYM_BIT1: begin
                        if (ron_q) begin
                            rsr_q <= {rsr_q[6:0], sym_code == `VPWL_SYM_BIT1};
                            rbit_q <= rbit_q + 3'h1;
                            if (rbit_q == 3'h7) begin
                                rsh_q <= {rsr_q[6:0], sym_code == `VPWL_SYM_BIT1};
                                receive_full_flag_q <= 1'b1;
                            end
                        end
                    end
                    `VPWL_SYM_INV: begin
                        // Short pulses, including unwanted fourfold rate, are noise
                        if (ron_q) inv_q <= 1'b1;
                        ron_q <= 1'b0;
                    end
                    `VPWL_SYM_EOD, `VPWL_SYM_EOF, `VPWL_SYM_EOFIFS, `VPWL_SYM_IDLE: begin
                        if (ron_q && rbit_q != 3'h0) inv_q <= 1'b1;
                        ron_q <= 1'b0;
                    end
                    default: ron_q <= ron_q;
                endcase
            end
            if (brk_stb) begin
                inv_q <= 1'b1;
                ron_q <= 1'b0;
                quad_q <= 1'b0;
            end
        end
    end

    // Age of the last rising edge, for joining a start of frame
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rise_age_q <= 7'h7F;
            drv_d1_q <= 1'b0;
            drv_d2_q <= 1'b0;
            mm_q <= 5'h00;
        end else begin
            if (rise_stb) rise_age_q <= 7'h00;
            else if (rise_age_q != 7'h7F) rise_age_q <= rise_age_q + 7'h01;
            // Own drive delayed to match the receive path
            drv_d1_q <= bus_transmit_output;
            drv_d2_q <= drv_d1_q;
            if (!busy || (rx == drv_d2_q)) mm_q <= 5'h00;
            else if (mm_q != `VPWL_ARB_FILT) mm_q <= mm_q + 5'h01;
        end
    end

    wire lose = busy && (mm_q == `VPWL_ARB_FILT);
    wire join_ok = eof_arm_q && rx && (rise_age_q <= JOIN_MAX);
    wire bval = (xtra_q != 2'h0) ? 1'b1 : tsh_q[7];
    // Short form: passive 0 and active 1
    wire [W-1:0] btime = (lvl_q ^ bval) ? P_T128 : P_T64;
    wire tdone = (tmr_q + 1'b1) >= btime;

    // Transmit sequencer
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q <= S_IDLE;
            bus_transmit_output <= 1'b0;
            tmr_q <= {W{1'b0}};
            bidx_q <= 3'h0;
            tsh_q <= 8'h00;
            tshd_q <= 8'h00;
            transmit_empty_flag_q <= 1'b1;
            lost_q <= 1'b0;
            first_q <= 1'b0;
            xtra_q <= 2'h0;
            lvl_q <= 1'b0;
        end else begin
            if (rd_state) lost_q <= 1'b0;
            if (wr_data) begin
                if (st_q == S_IDLE) begin
                    tsh_q <= hwdata[7:0];
                    st_q <= S_WAIT;
                end else begin
                    tshd_q <= hwdata[7:0];
                    transmit_empty_flag_q <= 1'b0;
                end
            end
            tmr_q <= tmr_q + 1'b1;
            case (st_q)
                S_IDLE: bus_transmit_output <= 1'b0;
                S_WAIT: begin
                    if (join_ok) begin
                        bus_transmit_output <= 1'b1;
                        tmr_q <= {{(W-7){1'b0}}, rise_age_q};
                        first_q <= 1'b1;
                        xtra_q <= 2'h0;
                        st_q <= S_SOF;
                    end else if (bus_idle) begin
                        bus_transmit_output <= 1'b1;
                        tmr_q <= {W{1'b0}};
                        first_q <= 1'b1;
                        xtra_q <= 2'h0;
                        st_q <= S_SOF;
                    end
                end
                S_SOF: begin
                    if (tmr_q + 1'b1 >= P_T200) begin
                        bus_transmit_output <= 1'b0;
                        st_q <= S_EDGE;
                    end
                end
                S_BIT: begin
                    if (tdone) begin
                        bus_transmit_output <= ~bus_transmit_output;
                        st_q <= S_EDGE;
                    end
                end
                S_EDGE: begin
                    if (rx == bus_transmit_output) begin
                        tmr_q <= {W{1'b0}};
                        lvl_q <= bus_transmit_output;
                        st_q <= S_BIT;
                        if (first_q) begin
                            first_q <= 1'b0;
                            bidx_q <= 3'h0;
                        end else if (xtra_q != 2'h0) begin
                            xtra_q <= xtra_q - 2'h1;
                            if (xtra_q == 2'h1) st_q <= S_IDLE;
                        end else if (bidx_q == 3'h7) begin
                            bidx_q <= 3'h0;
                            if (!transmit_empty_flag_q) begin
                                tsh_q <= tshd_q;
                                transmit_empty_flag_q <= 1'b1;
                            end else if (wr_data) begin
                                tsh_q <= hwdata[7:0];
                                transmit_empty_flag_q <= 1'b1;
                            end else begin
                                // Line stays passive: end of data
                                st_q <= S_IDLE;
                            end
                        end else begin
                            bidx_q <= bidx_q + 3'h1;
                            tsh_q <= {tsh_q[6:0], 1'b0};
                        end
                    end
                end
                S_XWAIT: begin
                    // Next bit starts on the winner's edge
                    if (rx != lvl_q) begin
                        lvl_q <= rx;
                        bus_transmit_output <= rx;
                        tmr_q <= {W{1'b0}};
                        st_q <= S_BIT;
                    end
                end
                default: st_q <= S_IDLE;
            endcase
            if (lose) begin
                bus_transmit_output <= 1'b0;
                lost_q <= 1'b1;
                if (xtra_q == 2'h0 && !first_q && bidx_q == 3'h7 && st_q == S_BIT) begin
                    xtra_q <= 2'h2;
                    st_q <= S_XWAIT;
                end else begin
                    xtra_q <= 2'h0;
                    st_q <= S_IDLE;
                end
            end
            if (brk_stb && busy) begin
                bus_transmit_output <= 1'b0;
                st_q <= S_IDLE;
            end
        end
    end
endmodule

//--- dv/vpwl_node.sv
// Behavioural VPW node on the far side of the wired-OR bus
`timescale 1ns/1ps
module vpwl_node #(
    parameter T64 = 40,
    parameter T128 = 80,
    parameter T200 = 120
) (
    // Clock
    input wire hclk,
    // Drive toward the bus, 1 = active
    output reg drv
);
    initial drv = 1'b0;
    task hold(input lvl, input integer n);
        begin
            drv <= lvl;
            repeat (n) @(posedge hclk);
        end
    endtask
    // Start of frame, eight bits MSB first, then passive; dv scales the rate
    task send(input [7:0] b, input integer dv);
        integer i;
        reg l;
        begin
            l = 1'b1;
            hold(1'b1, T200 / dv);
            for (i = 7; i >= 0; i = i - 1) begin
                l = ~l;
                hold(l, ((l ^ b[i]) ? T128 : T64) / dv);
            end
            drv <= 1'b0;
        end
    endtask
endmodule

//--- dv/vpwl_core_properties.sv
// Port checker for the VPW link controller
`timescale 1ns/1ps
`include "vpwl_regs.vh"
module vpwl_chk #(
    parameter [13:0] P_T64 = 14'h0028,
    parameter [13:0] P_T200 = 14'h0078
) (
    // Clock and reset
    input wire hclk,
    input wire hresetn,
    // Register bus
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [31:0] hwdata,
    input wire hready,
    input wire hreadyout,
    input wire hresp,
    input wire [31:0] hrdata,
    // Bus pin and interrupt
    input wire bus_transmit_output,
    input wire irq
);
    reg wd_q;
    reg wie_q;
    reg ie_q;
    reg [13:0] act_q;
    reg [13:0] pas_q;
    wire tk = hsel & htrans[1] & hready;
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wd_q <= 1'b0;
            wie_q <= 1'b0;
            ie_q <= 1'b0;
            act_q <= 14'h0000;
            pas_q <= 14'h0000;
        end else begin
            wd_q <= tk & hwrite;
            wie_q <= tk & hwrite & (haddr[7:0] == `VPWL_OFF_CTRL1);
            if (wie_q)
                ie_q <= hwdata[`VPWL_C1_IE];
            act_q <= bus_transmit_output ? act_q + 14'h0001 : 14'h0000;
            // Passive count saturates so a long idle cannot wrap
            pas_q <= bus_transmit_output ? 14'h0000 : pas_q + {13'h0000, ~&pas_q};
        end
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    ready_high_a: assert property ($past(hresetn) |-> hreadyout)
        else $error("hreadyout dropped");
    resp_okay_a: assert property (hresp == 1'b0)
        else $error("hresp not OKAY");
    upper_zero_a: assert property (hrdata[31:8] == 24'h000000)
        else $error("hrdata upper bits set");
    wr_rdata_zero_a: assert property (wd_q |-> hrdata == 32'h00000000)
        else $error("hrdata not zero after write");
    irq_masked_a: assert property (!ie_q && !$past(ie_q) |-> !irq)
        else $error("irq while disabled");
    act_max_a: assert property ($fell(bus_transmit_output) |-> act_q <= P_T200 + 14'h0001)
        else $error("active drive too long");
    act_min_a: assert property ($fell(bus_transmit_output) |-> act_q >= P_T64 - 14'h0001)
        else $error("active drive too short");
    pas_min_a: assert property ($rose(bus_transmit_output) |-> pas_q >= P_T64 - 14'h0001)
        else $error("passive gap too short");
    cover property ($rose(bus_transmit_output));
    cover property ($rose(irq));
    cover property (wd_q ##1 (tk & !hwrite));
endmodule
bind vpwl_core vpwl_chk #(.P_T64(P_T64), .P_T200(P_T200)) i_chk (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .bus_transmit_output(bus_transmit_output), .irq(irq));

//--- dv/tb_vpw_symbol_rx_arbitration.sv
// Self-checking bench for the VPW link controller
`timescale 1ns/1ps
`include "vpwl_regs.vh"
module tb_vpw_symbol_rx_arbitration;
    reg hclk;
    reg hresetn;
    reg hsel;
    reg [31:0] haddr;
    reg [1:0] htrans;
    reg hwrite;
    reg [2:0] hsize;
    reg [31:0] hwdata;
    reg ien;
    reg [31:0] rd;
    wire hreadyout;
    wire hresp;
    wire [31:0] hrdata;
    wire tx;
    wire irq;
    wire node_drv;
    wire bus_lvl = tx | node_drv;
    integer n_fail;
    integer n_tests;
    integer k;
    integer w;
    // Short bit of 40 cycles: limits 21/60/101/149/175/187, start of frame 125
    vpwl_core #(.P_T64(14'h0028)) i_dut (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .bus_receive_input(bus_lvl), .bus_transmit_output(tx), .irq(irq));
    vpwl_node i_node (.hclk(hclk), .drv(node_drv));
    initial begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end
    task test_done;
        begin
            if (n_fail == 0 && n_tests > 0)
                $display("*** PASS ***");
            else
                $display("*** FAIL ***");
            $finish;
        end
    endtask
    task chk(input [63:0] nm, input [31:0] e, input [31:0] g);
        begin
            n_tests = n_tests + 1;
            if (g !== e) begin
                n_fail = n_fail + 1;
                $display("CHECK FAILED %0s exp %h got %h", nm, e, g);
            end
        end
    endtask
    task wt;
        begin
            @(posedge hclk);
            while (hreadyout !== 1'b1)
                @(posedge hclk);
        end
    endtask
    // One single AHB-Lite transfer; read data lands in rd
    task ahb(input wr, input [7:0] a, input [31:0] d);
        begin
            hsel <= 1'b1;
            haddr <= {24'h000000, a};
            htrans <= 2'h2;
            hwrite <= wr;
            wt;
            hsel <= 1'b0;
            htrans <= 2'h0;
            hwdata <= d;
            wt;
            rd = hrdata;
        end
    endtask
    // Far node sends one byte; ok says whether it must be received
    task rxf(input [7:0] b, input integer dv, input ok);
        begin
            i_node.send(b, dv);
            repeat (250) @(posedge hclk);
            chk("irq", {31'h0, ok & ien}, irq);
            ahb(1'b0, `VPWL_OFF_STATE, 32'h0);
            chk("rxfull", {31'h0, ok}, rd & 32'h1);
            ahb(1'b0, `VPWL_OFF_DATA, 32'h0);
            if (ok)
                chk("rxbyte", {24'h0, b}, rd);
            ahb(1'b0, `VPWL_OFF_STATE, 32'h0);
            chk("rxclr", 32'h0, rd & 32'h1);
            chk("irqoff", 32'h0, irq);
        end
    endtask
    task t_brk;
        begin
            i_node.hold(1'b1, 200);
            i_node.hold(1'b0, 250);
            ahb(1'b0, `VPWL_OFF_STATE, 32'h0);
            chk("brk", 32'h8, rd & 32'h8);
            ahb(1'b0, `VPWL_OFF_CTRL2, 32'h0);
            chk("rx4xclr", 32'h0, rd & 32'h2);
        end
    endtask
    // Write while a frame is on the bus; start must wait for the separation
    task t_defer;
        begin
            fork
                i_node.send(8'h55, 1);
                begin
                    repeat (130) @(posedge hclk);
                    ahb(1'b1, `VPWL_OFF_DATA, 32'h3C);
                end
            join
            // Last bit still crosses the synchroniser and classifier
            repeat (8) @(posedge hclk);
            ahb(1'b0, `VPWL_OFF_DATA, 32'h0);
            chk("rx55", 32'h55, rd);
            k = 0;
            while (tx !== 1'b1 && k < 400) begin
                @(negedge hclk);
                k = k + 1;
            end
            chk("defer", 32'h1, {31'h0, k >= 178 && k <= 200});
            w = 0;
            while (tx === 1'b1 && w < 300) begin
                @(negedge hclk);
                w = w + 1;
            end
            chk("sof", 32'h7D, w);
            repeat (800) @(posedge hclk);
            ahb(1'b0, `VPWL_OFF_STATE, 32'h0);
            chk("txdone", 32'h3, rd & 32'h3);
            ahb(1'b0, `VPWL_OFF_DATA, 32'h0);
            chk("txback", 32'h3C, rd);
        end
    endtask
    // Both start together; our recessive first bit must lose
    task t_arb;
        begin
            fork
                i_node.send(8'h00, 1);
                ahb(1'b1, `VPWL_OFF_DATA, 32'h80);
            join
            repeat (300) @(posedge hclk);
            ahb(1'b0, `VPWL_OFF_STATE, 32'h0);
            chk("lost", 32'h11, rd & 32'h11);
            ahb(1'b0, `VPWL_OFF_DATA, 32'h0);
            chk("winner", 32'h0, rd);
        end
    endtask
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        ien = 1'b0;
        n_fail = 0;
        n_tests = 0;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        ahb(1'b0, `VPWL_OFF_STATE, 32'h0);
        chk("rststate", 32'h2, rd & 32'h1F);
        ien = 1'b1;
        ahb(1'b1, `VPWL_OFF_CTRL1, 32'h1);
        rxf(8'hA5, 1, 1'b1);
        ien = 1'b0;
        ahb(1'b1, `VPWL_OFF_CTRL1, 32'h0);
        ahb(1'b1, `VPWL_OFF_CTRL2, 32'h1);
        rxf(8'h5A, 1, 1'b0);
        ahb(1'b1, `VPWL_OFF_CTRL2, 32'h0);
        rxf(8'h96, 4, 1'b0);
        ahb(1'b1, `VPWL_OFF_CTRL2, 32'h2);
        rxf(8'h69, 4, 1'b1);
        t_brk;
        t_defer;
        t_arb;
        test_done;
    end
    initial begin
        repeat (20000) @(posedge hclk);
        n_fail = n_fail + 1;
        test_done;
    end
endmodule
